// ==== dv/sflc_checker.sv ====
// Port checker of the swing, length and count block
`default_nettype none
`include "sflc_defines.vh"
module sflc_checker
(
  // Clock and control
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // Terminals
  input wire logic length_pulse_in,
  input wire logic length_clear_in,
  input wire logic count_pulse_in,
  input wire logic length_reached,
  input wire logic count_final_reached,
  input wire logic count_mid_reached,
  input wire logic [15:0] out_freq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [15:0] sf_q, sw_q, up_q, lo_q;
  logic [2:0] qc_q;
  wire wctl = wr && ce && addr == `SFLC_A_CTRL;
  // Shadows cover only what the limit and plain-frequency checks need
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sf_q <= 16'h0;
      sw_q <= 16'h0;
      up_q <= `SFLC_RST_UP_LIM;
      lo_q <= 16'h0;
      qc_q <= 3'h0;
    end
    else if (ce)
    begin
      qc_q <= wr ? 3'h0 : qc_q + {2'h0, qc_q != 3'h7};
      if (wr && addr == `SFLC_A_SET_FREQ) sf_q <= wdata;
      if (wr && addr == `SFLC_A_SWING_PCT) sw_q <= wdata;
      if (wr && addr == `SFLC_A_UP_LIM) up_q <= wdata;
      if (wr && addr == `SFLC_A_LO_LIM) lo_q <= wdata;
    end
  end
  sequence s_len_clr;
    wctl && wdata[0];
  endsequence
  sequence s_len_drop;
    ##[1:4] !length_reached;
  endsequence
  property p_clamp;
    qc_q == 3'h7 |-> out_freq <= up_q && out_freq >= lo_q;
  endproperty
  a_clamp: assert property (p_clamp) else $error("freq off limits");
  property p_plain;
    qc_q == 3'h7 && sw_q == 16'h0 |-> out_freq == sf_q;
  endproperty
  a_plain: assert property (p_plain) else $error("freq not plain");
  property p_fin_hold;
    count_final_reached && ce && !(wctl && wdata[1]) |=> count_final_reached;
  endproperty
  a_fin_hold: assert property (p_fin_hold) else $error("final flag lost");
  property p_mid_hold;
    count_mid_reached && ce && !(wctl && wdata[1]) |=> count_mid_reached;
  endproperty
  a_mid_hold: assert property (p_mid_hold) else $error("mid flag lost");
  property p_fin_mid;
    $rose(count_final_reached) |-> count_mid_reached;
  endproperty
  a_fin_mid: assert property (p_fin_mid) else $error("mid flag missing");
  property p_cnt_clr;
    wctl && wdata[1] |=> !count_final_reached && !count_mid_reached;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("count flags kept");
  property p_len_clr;
    s_len_clr |-> s_len_drop;
  endproperty
  a_len_clr: assert property (p_len_clr) else $error("length kept");
  property p_status;
    rd && ce && addr == `SFLC_A_STATUS |=> rdata[0] == $past(length_reached);
  endproperty
  a_status: assert property (p_status) else $error("status bit wrong");
endmodule // sflc_checker
bind sflc_top sflc_checker sflc_checker_i (.clk_sys, .rst_n, .ce, .addr, .wdata, .wr, .rd,
  .rdata, .length_pulse_in, .length_clear_in, .count_pulse_in, .length_reached,
  .count_final_reached, .count_mid_reached, .out_freq);
`default_nettype wire

// ==== dv/sflc_pulse_src.sv ====
// Pulse source model feeding the length and count inputs
`default_nettype none
module sflc_pulse_src
(
  // Control
  input wire logic clk_sys,
  input wire logic start,
  input wire logic sel,
  input wire logic [7:0] n,
  // Pulses
  output logic len_p,
  output logic cnt_p,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_q = 8'h0;
  logic [2:0] ph_q = 3'h0;
  always @(posedge clk_sys)
  begin
    if (start)
    begin
      left_q <= n;
      ph_q <= 3'h0;
    end
    else if (busy)
    begin
      ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
      if (ph_q == 3'h5)
        left_q <= left_q - 8'h1;
    end
  end
  assign busy = left_q != 8'h0;
  assign len_p = busy && sel && ph_q < 3'h3;
  assign cnt_p = busy && !sel && ph_q < 3'h3;
endmodule // sflc_pulse_src
`default_nettype wire

// ==== dv/test_swing_freq_length_counter.sv ====
// Testbench of the swing, length and count block
`default_nettype none
`include "sflc_defines.vh"
module test_swing_freq_length_counter;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, length_clear_in = 0, go = 0, sel = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0, amp;
  logic [7:0] n = 8'h0;
  wire [15:0] rdata, out_freq;
  wire length_reached, count_final_reached, count_mid_reached, lp, cp, busy;
  int num_errors = 0, total_checks = 0;
  // mid not above final
  // Rows: index, reset value, written value, read back
  logic [51:0] rows [9] = '{{4'h0, 16'h0, 16'h1, 16'h1}, {4'h2, 16'h0, 16'h1f4, 16'h1f4},
    {4'h3, `SFLC_RST_PERIOD, 16'h2, 16'h2}, {4'h4, `SFLC_RST_RISE_COEF, 16'h1f4, 16'h1f4},
    {4'h5, 16'h3e8, 16'h2, 16'h2}, {4'h6, 16'h0, 16'h55, 16'h0},
    {4'h7, `SFLC_RST_PPM, 16'ha, 16'ha}, {4'h8, 16'h3e8, 16'h3, 16'h3},
    {4'h9, 16'h3e8, 16'h2, 16'h2}};
  sflc_top sflc_top_i (.clk_sys, .rst_n, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .length_pulse_in(lp), .length_clear_in, .count_pulse_in(cp), .length_reached,
    .count_final_reached, .count_mid_reached, .out_freq);
  sflc_pulse_src sflc_pulse_src_i (.clk_sys, .start(go), .sel, .n, .len_p(lp), .cnt_p(cp),
    .busy);
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk_sys);
    wr <= 0;
  endtask
  task rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1;
    @(posedge clk_sys);
    rd <= 0;
    @(negedge clk_sys);
    chk(rdata, e);
  endtask
  task pulses(input logic s, input logic [7:0] k);
    @(posedge clk_sys);
    sel <= s;
    n <= k;
    go <= 1;
    @(posedge clk_sys);
    go <= 0;
    for (int i = 0; i < 2000 && (busy || i < 2); i++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  function automatic logic [15:0] flags();
    return {13'h0, count_mid_reached, count_final_reached, length_reached};
  endfunction
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (15) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(out_freq, 16'h0);
    @(posedge clk_sys);
    rst_n <= 1;
    foreach (rows[i])
    begin
      rchk(rows[i][51:48], rows[i][47:32]);
      wreg(rows[i][51:48], rows[i][31:16]);
      rchk(rows[i][51:48], rows[i][15:0]);
    end
    wreg(`SFLC_A_STATUS, 16'hffff);
    rchk(`SFLC_A_STATUS, 16'h0);
    pulses(0, 2);
    chk(flags(), 16'h4);
    pulses(0, 1);
    chk(flags(), 16'h6);
    pulses(0, 2);
    rchk(`SFLC_A_CTRL, 16'h3);
    wreg(`SFLC_A_CTRL, 16'h2);
    rchk(`SFLC_A_CTRL, 16'h0);
    chk(flags(), 16'h0);
    pulses(1, 2);
    rchk(`SFLC_A_MEAS_LEN, 16'h2);
    chk(flags(), 16'h0);
    pulses(1, 1);
    chk(flags(), 16'h1);
    rchk(`SFLC_A_STATUS, 16'h1);
    wreg(`SFLC_A_CTRL, 16'h1);
    rchk(`SFLC_A_MEAS_LEN, 16'h0);
    chk(flags(), 16'h0);
    wreg(`SFLC_A_PPM, 16'h14);
    pulses(1, 4);
    rchk(`SFLC_A_MEAS_LEN, 16'h2);
    @(posedge clk_sys);
    length_clear_in <= 1;
    repeat (3) @(posedge clk_sys);
    length_clear_in <= 0;
    // Clear edge passes two sync stages, edge detect and two register stages
    repeat (4) @(posedge clk_sys);
    rchk(`SFLC_A_MEAS_LEN, 16'h0);
    wreg(`SFLC_A_SET_FREQ, 16'h3e8);
    repeat (8) @(negedge clk_sys);
    chk(out_freq, 16'h3e8);
    // Swing starts at the low end of the rise, centre minus amplitude plus jump
    for (int b = 0; b < 2; b++)
    begin
      amp = b ? 16'h1f4 : 16'h64;
      wreg(`SFLC_A_BASE_SEL, 16'(b));
      wreg(`SFLC_A_SWING_PCT, 16'h64);
      repeat (8) @(negedge clk_sys);
      chk(out_freq, 16'h3e8 - amp + amp / 2);
    end
    wreg(`SFLC_A_LO_LIM, 16'h3b6);
    repeat (8) @(negedge clk_sys);
    chk(out_freq, 16'h3b6);
    wreg(`SFLC_A_LO_LIM, 16'h0);
    wreg(`SFLC_A_UP_LIM, 16'h2bc);
    repeat (8) @(negedge clk_sys);
    chk(out_freq, 16'h2bc);
    // Doubled percentage saturates at full scale, jump at half of it
    wreg(`SFLC_A_BASE_SEL, 16'h0);
    wreg(`SFLC_A_SWING_PCT, 16'h7d0);
    repeat (8) @(negedge clk_sys);
    chk(out_freq, 16'h1f4);
    wreg(`SFLC_A_JUMP_PCT, 16'h3e8);
    repeat (8) @(negedge clk_sys);
    chk(out_freq, 16'h1f4);
    give_verdict();
  end
endmodule // test_swing_freq_length_counter
`default_nettype wire

// ==== rtl/sflc_defines.vh ====
// Register map, reset values and timing constants of the swing, length and count block
`ifndef SFLC_DEFINES_VH
`define SFLC_DEFINES_VH
`define SFLC_A_BASE_SEL 4'h0
`define SFLC_A_SWING_PCT 4'h1
`define SFLC_A_JUMP_PCT 4'h2
`define SFLC_A_PERIOD 4'h3
`define SFLC_A_RISE_COEF 4'h4
`define SFLC_A_TGT_LEN 4'h5
`define SFLC_A_MEAS_LEN 4'h6
`define SFLC_A_PPM 4'h7
`define SFLC_A_FINAL_CNT 4'h8
`define SFLC_A_MID_CNT 4'h9
`define SFLC_A_SET_FREQ 4'ha
`define SFLC_A_MAX_FREQ 4'hb
`define SFLC_A_UP_LIM 4'hc
`define SFLC_A_LO_LIM 4'hd
`define SFLC_A_CTRL 4'he
`define SFLC_A_STATUS 4'hf
`define SFLC_RST_TGT_LEN 16'h03e8
`define SFLC_RST_FINAL_CNT 16'h03e8
`define SFLC_RST_MID_CNT 16'h03e8
`define SFLC_RST_PERIOD 16'h0064
`define SFLC_RST_RISE_COEF 16'h01f4
`define SFLC_RST_PPM 16'h03e8
`define SFLC_RST_MAX_FREQ 16'h1388
`define SFLC_RST_UP_LIM 16'h1388
`define SFLC_PCT_FULL 16'h03e8
`define SFLC_PCT_JUMP_MAX 16'h01f4
`define SFLC_CTRL_LEN_CLR 0
`define SFLC_CTRL_CNT_CLR 1
`define SFLC_STEP_TIME_MS 100
`define SFLC_CLK_KHZ 10000
`define SFLC_STEP_CYCLES (`SFLC_STEP_TIME_MS * `SFLC_CLK_KHZ)
`endif

// ==== rtl/sflc_pct.v ====
// Scales a 16-bit value by a per-mille factor
`default_nettype none
module sflc_pct
(
  // Operands
  input wire [15:0] base,
  input wire [15:0] permille,
  // Result
  output wire [15:0] result
);
  wire [31:0] prod;
  wire [31:0] quot;
  assign prod = {16'h0000, base} * {16'h0000, permille};
  assign quot = prod / 32'd1000;
  assign result = (quot > 32'h0000ffff) ? 16'hffff : quot[15:0];
endmodule // sflc_pct
`default_nettype wire

// ==== rtl/sflc_sync.v ====
// Two-flop synchroniser with rising-edge pulse output
`default_nettype none
module sflc_sync
(
  // Clock and control
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Signal
  input wire din,
  output reg rise
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      rise <= 1'b0;
    end
    else if (ce)
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise <= s2_q & ~s3_q;
    end
  end
endmodule // sflc_sync
`default_nettype wire

// ==== rtl/sflc_top.v ====
// Swing frequency, fixed length and count logic of a motor drive
// Function
// - The output frequency moves along a triangle centred on the set frequency.
// - A zero swing amplitude gives the plain set frequency.
// - The base selector picks set frequency (0) or maximum frequency (1) as amplitude base.
// - Actual amplitude is base times swing percentage, limited to 0 to 100.0 percent.
// - Jump step is amplitude times jump percentage, limited to 0 to 50.0 percent.
// - The swinging frequency is clamped between upper and lower frequency limits.
// - One cycle lasts the set period, rising for period times coefficient, falling the rest.
// - Actual length is ten times the collected length pulses divided by pulses per meter.
// - The length-reached output turns on once actual length exceeds set length.
// - The length-clear input clears the accumulated length.
// - At the final count the final-reached output turns on and counting stops.
// - At the intermediate count its output turns on and counting goes on.
`include "sflc_defines.vh"
`default_nettype none
module sflc_top
(
  // Clock, reset, enable
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // Terminals
  input wire length_pulse_in,
  input wire length_clear_in,
  input wire count_pulse_in,
  output reg length_reached,
  output reg count_final_reached,
  output reg count_mid_reached,
  // Frequency output, 0.01 Hz units
  output reg [15:0] out_freq
);
  localparam ST_RISE = 2'b01;
  localparam ST_FALL = 2'b10;
  localparam [31:0] STEP_LAST = `SFLC_STEP_CYCLES - 1;
  reg [15:0] base_sel_q;
  reg [15:0] swing_pct_q;
  reg [15:0] jump_pct_q;
  reg [15:0] period_q;
  reg [15:0] rise_coef_q;
  reg [15:0] tgt_len_q;
  reg [15:0] meas_len_q;
  reg [15:0] ppm_q;
  reg [15:0] final_cnt_q;
  reg [15:0] mid_cnt_q;
  reg [15:0] set_freq_q;
  reg [15:0] max_freq_q;
  reg [15:0] up_lim_q;
  reg [15:0] lo_lim_q;
  reg [15:0] count_q;
  reg [15:0] len_pulses_q;
  reg [1:0] state_q;
  reg [19:0] tick_q;
  reg [15:0] step_q;
  wire len_rise;
  wire clr_rise;
  wire cnt_rise;
  wire step_tick;
  wire [15:0] amp_base;
  wire [15:0] amp;
  wire [15:0] jump;
  wire [15:0] rise_steps;
  wire [15:0] swing_pct_lim;
  wire [15:0] jump_pct_lim;
  wire [15:0] len_per_ppm;
  wire [31:0] len_calc;
  wire [31:0] tri_calc;
  wire [15:0] tri_off;
  wire [17:0] raw_freq;
  wire [17:0] clamp_freq;
  sflc_sync u_len
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .din(length_pulse_in),
    .rise(len_rise)
  );
  sflc_sync u_clr
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .din(length_clear_in),
    .rise(clr_rise)
  );
  sflc_sync u_cnt
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .din(count_pulse_in),
    .rise(cnt_rise)
  );
  assign swing_pct_lim = (swing_pct_q > `SFLC_PCT_FULL) ? `SFLC_PCT_FULL : swing_pct_q;
  assign jump_pct_lim = (jump_pct_q > `SFLC_PCT_JUMP_MAX) ? `SFLC_PCT_JUMP_MAX : jump_pct_q;
  assign amp_base = base_sel_q[0] ? max_freq_q : set_freq_q;
  sflc_pct u_amp
  (
    .base(amp_base),
    .permille(swing_pct_lim),
    .result(amp)
  );
  sflc_pct u_jump
  (
    .base(amp),
    .permille(jump_pct_lim),
    .result(jump)
  );
  sflc_pct u_rise
  (
    .base(period_q),
    .permille(rise_coef_q > `SFLC_PCT_FULL ? `SFLC_PCT_FULL : rise_coef_q),
    .result(rise_steps)
  );
  // Period counts 0.1 s steps; a sub-step ramp still lasts one step, held at its start value
  assign step_tick = (tick_q == STEP_LAST[19:0]);
  // A zero-length ramp would divide by zero, so its offset is held at zero
  assign tri_calc = (state_q == ST_RISE)
    ? ((rise_steps == 16'h0000) ? 32'h00000000 :
      ({16'h0000, amp} * {16'h0000, step_q}) / {16'h0000, rise_steps})
    : ((period_q == rise_steps) ? 32'h00000000 :
      ({16'h0000, amp} * {16'h0000, step_q}) / {16'h0000, period_q - rise_steps});
  assign tri_off = (tri_calc > {16'h0000, amp}) ? amp : tri_calc[15:0];
  // triangle around centre, jump at each turn
  assign raw_freq = (state_q == ST_RISE)
    ? {2'b00, set_freq_q} - {2'b00, amp} + {2'b00, jump} + {1'b0, tri_off, 1'b0}
    : {2'b00, set_freq_q} + {2'b00, amp} - {2'b00, jump} - {1'b0, tri_off, 1'b0};
  assign clamp_freq = raw_freq[17] ? {2'b00, lo_lim_q} :
    (raw_freq > {2'b00, up_lim_q}) ? {2'b00, up_lim_q} :
    (raw_freq < {2'b00, lo_lim_q}) ? {2'b00, lo_lim_q} : raw_freq;
  assign len_calc = (ppm_q == 16'h0000) ? 32'h00000000 :
    ({16'h0000, len_pulses_q} * 32'd10) / {16'h0000, ppm_q};
  assign len_per_ppm = (len_calc > 32'h0000ffff) ? 16'hffff : len_calc[15:0];
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      base_sel_q <= 16'h0000;
      swing_pct_q <= 16'h0000;
      jump_pct_q <= 16'h0000;
      period_q <= `SFLC_RST_PERIOD;
      rise_coef_q <= `SFLC_RST_RISE_COEF;
      tgt_len_q <= `SFLC_RST_TGT_LEN;
      ppm_q <= `SFLC_RST_PPM;
      final_cnt_q <= `SFLC_RST_FINAL_CNT;
      mid_cnt_q <= `SFLC_RST_MID_CNT;
      set_freq_q <= 16'h0000;
      max_freq_q <= `SFLC_RST_MAX_FREQ;
      up_lim_q <= `SFLC_RST_UP_LIM;
      lo_lim_q <= 16'h0000;
      rdata <= 16'h0000;
    end
    else if (ce)
    begin
      if (wr)
      begin
        case (addr)
          `SFLC_A_BASE_SEL: base_sel_q <= wdata;
          `SFLC_A_SWING_PCT: swing_pct_q <= wdata;
          `SFLC_A_JUMP_PCT: jump_pct_q <= wdata;
          `SFLC_A_PERIOD: period_q <= wdata;
          `SFLC_A_RISE_COEF: rise_coef_q <= wdata;
          `SFLC_A_TGT_LEN: tgt_len_q <= wdata;
          `SFLC_A_PPM: ppm_q <= wdata;
          `SFLC_A_FINAL_CNT: final_cnt_q <= wdata;
          `SFLC_A_MID_CNT: mid_cnt_q <= wdata;
          `SFLC_A_SET_FREQ: set_freq_q <= wdata;
          `SFLC_A_MAX_FREQ: max_freq_q <= wdata;
          `SFLC_A_UP_LIM: up_lim_q <= wdata;
          `SFLC_A_LO_LIM: lo_lim_q <= wdata;
          default: ;
        endcase
      end
      rdata <= 16'h0000;
      if (rd)
      begin
        case (addr)
          `SFLC_A_BASE_SEL: rdata <= base_sel_q;
          `SFLC_A_SWING_PCT: rdata <= swing_pct_q;
          `SFLC_A_JUMP_PCT: rdata <= jump_pct_q;
          `SFLC_A_PERIOD: rdata <= period_q;
          `SFLC_A_RISE_COEF: rdata <= rise_coef_q;
          `SFLC_A_TGT_LEN: rdata <= tgt_len_q;
          `SFLC_A_MEAS_LEN: rdata <= meas_len_q;
          `SFLC_A_PPM: rdata <= ppm_q;
          `SFLC_A_FINAL_CNT: rdata <= final_cnt_q;
          `SFLC_A_MID_CNT: rdata <= mid_cnt_q;
          `SFLC_A_SET_FREQ: rdata <= set_freq_q;
          `SFLC_A_MAX_FREQ: rdata <= max_freq_q;
          `SFLC_A_UP_LIM: rdata <= up_lim_q;
          `SFLC_A_LO_LIM: rdata <= lo_lim_q;
          `SFLC_A_CTRL: rdata <= count_q;
          `SFLC_A_STATUS: rdata <= {13'h0, count_mid_reached, count_final_reached,
            length_reached};
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end
  // Swing triangle sequencer
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q <= ST_RISE;
      tick_q <= 20'h00000;
      step_q <= 16'h0000;
      out_freq <= 16'h0000;
    end
    else if (ce)
    begin
      tick_q <= step_tick ? 20'h00000 : tick_q + 20'h00001;
      if (step_tick)
      begin
        case (state_q)
          ST_RISE:
          begin
            if (step_q + 16'h0001 >= rise_steps)
            begin
              state_q <= ST_FALL;
              step_q <= 16'h0000;
            end
            else
              step_q <= step_q + 16'h0001;
          end
          ST_FALL:
          begin
            if (step_q + 16'h0001 >= period_q - rise_steps)
            begin
              state_q <= ST_RISE;
              step_q <= 16'h0000;
            end
            else
              step_q <= step_q + 16'h0001;
          end
          default:
          begin
            state_q <= ST_RISE;
            step_q <= 16'h0000;
          end
        endcase
      end
      if (swing_pct_q == 16'h0000)
        out_freq <= set_freq_q;
      else
        out_freq <= clamp_freq[15:0];
    end
  end
  // Length and count
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      len_pulses_q <= 16'h0000;
      meas_len_q <= 16'h0000;
      length_reached <= 1'b0;
      count_q <= 16'h0000;
      count_final_reached <= 1'b0;
      count_mid_reached <= 1'b0;
    end
    else if (ce)
    begin
      if (clr_rise || (wr && addr == `SFLC_A_CTRL && wdata[`SFLC_CTRL_LEN_CLR]))
        len_pulses_q <= 16'h0000;
      else if (len_rise && len_pulses_q != 16'hffff)
        len_pulses_q <= len_pulses_q + 16'h0001;
      meas_len_q <= len_per_ppm;
      length_reached <= (meas_len_q > tgt_len_q);
      if (wr && addr == `SFLC_A_CTRL && wdata[`SFLC_CTRL_CNT_CLR])
      begin
        count_q <= 16'h0000;
        count_final_reached <= 1'b0;
        count_mid_reached <= 1'b0;
      end
      else if (cnt_rise && !count_final_reached)
      begin
        count_q <= count_q + 16'h0001;
        if (count_q + 16'h0001 >= final_cnt_q)
          count_final_reached <= 1'b1;
        if (count_q + 16'h0001 >= mid_cnt_q)
          count_mid_reached <= 1'b1;
      end
    end
  end
endmodule // sflc_top
`default_nettype wire
